// ==== src/amg_pkg.sv ====
// Package for the modulo and bit-reversed address generator.
// Assumes a 32-bit AHB-Lite register bus and a 16-bit core datapath.
package amg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_XSTART = 8'h04;
  localparam logic [7:0] OFS_XEND   = 8'h08;
  localparam logic [7:0] OFS_YSTART = 8'h0C;
  localparam logic [7:0] OFS_YEND   = 8'h10;
  localparam logic [7:0] OFS_BREV   = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  localparam logic [7:0] OFS_LAST   = 8'h1C;
  // Control field positions
  localparam int XSEL_LSB = 0;
  localparam int YSEL_LSB = 4;
  localparam int BSEL_LSB = 8;
  localparam int YEN_BIT  = 14;
  localparam int XEN_BIT  = 15;
  // Reverse-carry control field positions
  localparam int BEN_BIT  = 15;
  localparam int PIV_MSB  = 14;
  // Pointer select code that means no pointer
  localparam logic [3:0] NO_PTR = 4'hF;
  // Reset values
  localparam logic [15:0] RST_CTRL = 16'h0FFF;
  localparam logic [15:0] RST_REG  = 16'h0000;
  // Address generators
  typedef enum logic [1:0] {
    GEN_XRD = 2'h0,
    GEN_XWR = 2'h1,
    GEN_Y   = 2'h2
  } amg_gen_t;
  // Addressing modes
  typedef enum logic [2:0] {
    M_IND     = 3'h0,
    M_POSTINC = 3'h1,
    M_POSTDEC = 3'h2,
    M_PREINC  = 3'h3,
    M_PREDEC  = 3'h4,
    M_OFFSET  = 3'h5
  } amg_mode_t;
  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RD   = 2'b10
  } amg_state_t;
endpackage : amg_pkg

// ==== src/amg_modulo.sv ====
// Circular buffer boundary correction.
// Assumes start and end bound one buffer with start not above end.
`timescale 1ns/1ps
module amg_modulo
  import amg_pkg::*;
(
  // Candidate address and direction
  input  wire logic [15:0] addr,
  input  wire logic        up,
  input  wire logic        down,
  // Buffer bounds
  input  wire logic [15:0] start_a,
  input  wire logic [15:0] end_a,
  // Result
  output logic      [15:0] fixed,
  output logic             wrapped
);
  logic [15:0] len;   // Buffer length in bytes
  logic        above; // Passed upper bound
  logic        below; // Passed lower bound

  // Length follows from the bounds, up to 32K words
  assign len   = 16'(end_a - start_a + 16'h0001); // RL3
  // Passing a bound counts, not only landing on it
  assign above = up & (addr > end_a);     // RL6
  assign below = down & (addr < start_a); // RL6
  // Each access checks only its own direction; both
  // directions are safe for power-of-two lengths
  assign wrapped = above | below; // RL7
  // Wrap back into the buffer by its length
  assign fixed = above ? 16'(addr - len) :
                 below ? 16'(addr + len) : addr; // RL18
endmodule : amg_modulo

// ==== src/amg_bitrev.sv ====
// Reverse-carry adder for bit-reversed pointer updates.
// Assumes word data; the pivot is a word count.
`timescale 1ns/1ps
module amg_bitrev
  import amg_pkg::*;
(
  // Pointer and pivot
  input  wire logic [15:0] ptr,
  input  wire logic [14:0] pivot,
  // Reversed-carry sum
  output logic      [15:0] sum
);
  logic [15:0] piv_b; // Pivot scaled to bytes
  logic [15:0] r_ptr; // Mirrored pointer
  logic [15:0] r_piv; // Mirrored pivot
  logic [15:0] r_sum; // Mirrored sum
  logic [15:0] s_raw; // Sum back in normal order

  // Word pivot becomes a byte modifier
  assign piv_b = {pivot, 1'b0}; // RL12
  // Mirror the operands so carries run downward
  genvar i;
  for (i = 0; i < 16; i++) begin : g_mir
    assign r_ptr[i] = ptr[15-i];
    assign r_piv[i] = piv_b[15-i];
    assign s_raw[i] = r_sum[15-i]; // RL17
  end
  assign r_sum = 16'(r_ptr + r_piv); // RL14
  // Word data: address bit zero stays clear
  assign sum = {s_raw[15:1], 1'b0}; // RL14
endmodule : amg_bitrev

// ==== src/amg_core.sv ====
// Effective address correction with register slave.
// Assumes one AHB-Lite master and a core issuing one request per cycle.
//
// Contract
// [RL1] X modulo needs enable and select not 15
// [RL2] Y modulo needs enable and select not 15
// [RL3] Start and end registers bound each buffer
// [RL4] One X buffer and one Y buffer
// [RL5] Y modulo addresses keep bit zero clear
// [RL6] Boundary passed, not only reached, triggers
// [RL7] Power-of-two buffers work both directions
// [RL8] Writeback only for pre or post modify
// [RL9] Bit reversal only for X data writes
// [RL10] Bit reversal needs select, enable, increment mode
// [RL11] Software aligns bit-reversed buffer start
// [RL12] Pivot scaled to byte address
// [RL13] Byte or other modes give normal addresses
// [RL14] Reversed carry add, mode step ignored
// [RL15] Bit reversal overrides X write modulo
// [RL16] Software avoids read right after control write
// [RL17] Sixteen entries map to mirrored index
// [RL18] Crossing wraps address by buffer length
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module amg_core
  import amg_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Core request
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_gen,
  input  wire logic [3:0]  req_reg,
  input  wire logic [15:0] req_ptr,
  input  wire logic [15:0] req_step,
  input  wire logic [2:0]  req_mode,
  input  wire logic        req_byte,
  // Core answer
  output logic             ea_valid,
  output logic      [15:0] ea,
  output logic             wb_valid,
  output logic      [3:0]  wb_reg,
  output logic      [15:0] wb_data,
  output logic             ea_wrapped,
  output logic             ea_reversed
);
  // Software registers
  logic [15:0] addr_mode_control;
  logic [15:0] x_buffer_start;
  logic [15:0] x_buffer_end;
  logic [15:0] y_buffer_start;
  logic [15:0] y_buffer_end;
  logic [15:0] reverse_carry_control;

  // Bus slave state
  amg_state_t  state;
  logic        wr_pend;  // Write data phase pending
  logic [7:0]  wr_addr;  // Write target offset
  logic [7:0]  rd_addr;  // Read target offset

  // Bus decode
  logic        take;     // Transfer accepted
  logic        take_rd;  // Read accepted
  logic        take_wr;  // Write accepted
  logic [31:0] rd_mux;   // Read data select
  logic [15:0] wd;       // Write data low half

  // Address phase accepted on hready with NONSEQ or SEQ
  assign take    = hsel & hready & htrans[1];
  assign take_rd = take & ~hwrite;
  assign take_wr = take & hwrite;
  assign wd      = hwdata[15:0];

  // Register read select, unmapped reads as zero
  assign rd_mux =
    (rd_addr == OFS_CTRL)   ? {16'h0000, addr_mode_control} :
    (rd_addr == OFS_XSTART) ? {16'h0000, x_buffer_start} :
    (rd_addr == OFS_XEND)   ? {16'h0000, x_buffer_end} :
    (rd_addr == OFS_YSTART) ? {16'h0000, y_buffer_start} :
    (rd_addr == OFS_YEND)   ? {16'h0000, y_buffer_end} :
    (rd_addr == OFS_BREV)   ? {16'h0000, reverse_carry_control} :
    (rd_addr == OFS_STAT)   ? {30'h0, ea_reversed, ea_wrapped} :
    (rd_addr == OFS_LAST)   ? {16'h0000, ea} : 32'h00000000;

  // Bus state: reads take one wait state so that a write
  // in the data phase just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      hreadyout <= 1'b1;
      rd_addr   <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Latch read target and stall one cycle
          if (take_rd) begin
            state     <= ST_RD;
            hreadyout <= 1'b0;
            rd_addr   <= haddr[7:0];
          end
        end
        ST_RD: begin
          // Data ready on the next edge
          state     <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Read data and response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hresp  <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (state == ST_RD) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Write address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take_wr;
      if (take_wr) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_mode_control     <= RST_CTRL;
      x_buffer_start        <= RST_REG;
      x_buffer_end          <= RST_REG;
      y_buffer_start        <= RST_REG;
      y_buffer_end          <= RST_REG;
      reverse_carry_control <= RST_REG;
    end else if (wr_pend) begin
      // Status and unmapped offsets ignore writes
      if (wr_addr == OFS_CTRL)   addr_mode_control     <= wd;
      if (wr_addr == OFS_XSTART) x_buffer_start        <= wd;
      if (wr_addr == OFS_XEND)   x_buffer_end          <= wd;
      if (wr_addr == OFS_YSTART) y_buffer_start        <= wd;
      if (wr_addr == OFS_YEND)   y_buffer_end          <= wd;
      if (wr_addr == OFS_BREV)   reverse_carry_control <= wd;
    end
  end

  // Control fields
  logic [3:0]  x_mod_pointer_select;
  logic [3:0]  y_mod_pointer_select;
  logic [3:0]  bitrev_pointer_select;
  logic        x_mod_enable;
  logic        y_mod_enable;
  logic        bitrev_enable;
  logic [14:0] bitrev_pivot;

  assign x_mod_pointer_select  = addr_mode_control[XSEL_LSB +: 4];
  assign y_mod_pointer_select  = addr_mode_control[YSEL_LSB +: 4];
  assign bitrev_pointer_select = addr_mode_control[BSEL_LSB +: 4];
  assign x_mod_enable  = addr_mode_control[XEN_BIT];
  assign y_mod_enable  = addr_mode_control[YEN_BIT];
  assign bitrev_enable = reverse_carry_control[BEN_BIT];
  assign bitrev_pivot  = reverse_carry_control[PIV_MSB:0];

  // Request decode
  logic        is_x;     // X read or X write generator
  logic        is_y;     // Y generator
  logic        inc;      // Increment mode
  logic        dec;      // Decrement mode
  logic        pre;      // Pre-modify mode
  logic        ofs;      // Register plus offset
  logic        dir_up;   // Address moves upward
  logic        dir_dn;   // Address moves downward
  logic [15:0] delta;    // Signed modifier
  logic [15:0] raw_new;  // Unc orrected new address

  assign is_x = (req_gen == GEN_XRD) | (req_gen == GEN_XWR);
  assign is_y = (req_gen == GEN_Y);
  assign inc  = (req_mode == M_POSTINC) | (req_mode == M_PREINC);
  assign dec  = (req_mode == M_POSTDEC) | (req_mode == M_PREDEC);
  assign pre  = (req_mode == M_PREINC) | (req_mode == M_PREDEC);
  assign ofs  = (req_mode == M_OFFSET);
  // Offset sign gives its direction
  assign dir_up = inc | (ofs & ~req_step[15]);
  assign dir_dn = dec | (ofs & req_step[15]);
  assign delta  = dec ? 16'(-req_step) :
                  (inc | ofs) ? req_step : 16'h0000;
  assign raw_new = 16'(req_ptr + delta);

  // Mode enables
  logic xmod_on;   // X modulo applies
  logic ymod_on;   // Y modulo applies
  logic brev_on;   // Bit reversal applies
  logic mod_on;    // Modulo used for this access

  // Independent X and Y buffers at once
  assign xmod_on = is_x & x_mod_enable &
                   (x_mod_pointer_select != NO_PTR) &
                   (req_reg == x_mod_pointer_select); // RL1 RL4
  assign ymod_on = is_y & y_mod_enable &
                   (y_mod_pointer_select != NO_PTR) &
                   (req_reg == y_mod_pointer_select); // RL2 RL4
  // Only X writes, word size, increment modes
  assign brev_on = (req_gen == GEN_XWR) & bitrev_enable &
                   (bitrev_pointer_select != NO_PTR) &
                   (req_reg == bitrev_pointer_select) &
                   ~req_byte & inc; // RL9 RL10 RL13
  // Bit reversal wins on the X write generator only
  assign mod_on = (xmod_on | ymod_on) & ~brev_on; // RL15

  // Buffer bounds of the selected space
  logic [15:0] sel_start;
  logic [15:0] sel_end;
  logic [15:0] mod_addr;
  logic        mod_wrap;
  logic [15:0] rev_addr;

  assign sel_start = is_y ? y_buffer_start : x_buffer_start; // RL3
  assign sel_end   = is_y ? y_buffer_end : x_buffer_end;     // RL3

  // Boundary correction
  amg_modulo u_modulo (
    .addr    (raw_new),
    .up      (dir_up),
    .down    (dir_dn),
    .start_a (sel_start),
    .end_a   (sel_end),
    .fixed   (mod_addr),
    .wrapped (mod_wrap)
  );

  // Reverse-carry update, mode step ignored
  amg_bitrev u_bitrev (
    .ptr   (req_ptr),
    .pivot (bitrev_pivot),
    .sum   (rev_addr)
  );

  // Result selection
  logic [15:0] upd;       // Updated pointer value
  logic [15:0] upd_w;     // After word alignment
  logic [15:0] next_ea;   // Effective address
  logic        next_wb;   // Pointer written back
  logic        next_wrap; // Correction applied
  logic [15:0] old_w;     // Old pointer after word alignment

  assign next_wrap = mod_on & mod_wrap;
  assign upd = brev_on ? rev_addr :
               mod_on ? mod_addr : raw_new; // RL14 RL18
  // Y modulo treats data as words
  assign upd_w = ymod_on ? {upd[15:1], 1'b0} : upd; // RL5
  assign old_w = ymod_on ? {req_ptr[15:1], 1'b0} : req_ptr; // RL5
  // Pre-modify and offset use the new address,
  // indirect and post-modify use the old pointer
  assign next_ea = (pre | ofs) ? upd_w : old_w; // RL8
  // Offset mode corrects the access only
  assign next_wb = inc | dec; // RL8

  // Registered answer to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ea_valid    <= 1'b0;
      ea          <= 16'h0000;
      wb_valid    <= 1'b0;
      wb_reg      <= 4'h0;
      wb_data     <= 16'h0000;
      ea_wrapped  <= 1'b0;
      ea_reversed <= 1'b0;
    end else begin
      ea_valid <= req_valid;
      wb_valid <= req_valid & next_wb; // RL8
      if (req_valid) begin
        ea          <= next_ea;
        wb_reg      <= req_reg;
        wb_data     <= upd_w;
        ea_wrapped  <= next_wrap;
        ea_reversed <= brev_on;
      end
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_take_s;
    hreadyout && take_rd && state == ST_IDLE;
  endsequence
  sequence rd_done_s;
    !hreadyout ##1 hreadyout;
  endsequence

  rd_wait_a: assert property (rd_take_s |=> rd_done_s)
    else $error("read wait state wrong");
  x_sel_off_a: assert property ( // RL1
    req_valid && is_x && x_mod_pointer_select == NO_PTR
    |=> !ea_wrapped)
    else $error("x modulo active with no pointer");
  y_en_off_a: assert property ( // RL2
    req_valid && is_y && !y_mod_enable |=> !ea_wrapped)
    else $error("y modulo active while disabled");
  y_word_a: assert property ( // RL5
    req_valid && ymod_on |=> !ea[0] && !wb_data[0])
    else $error("y modulo address odd");
  wrap_up_a: assert property ( // RL6
    req_valid && mod_on && dir_up && raw_new > sel_end
    |=> ea_wrapped && wb_data == $past(16'(raw_new - sel_end
        + sel_start - 16'h0001) & (ymod_on ? 16'hFFFE : 16'hFFFF)))
    else $error("upward crossing not wrapped");
  wrap_dn_a: assert property ( // RL18
    req_valid && mod_on && dir_dn && raw_new < sel_start
    |=> ea_wrapped && wb_data == $past(16'(raw_new + sel_end
        - sel_start + 16'h0001) & (ymod_on ? 16'hFFFE : 16'hFFFF)))
    else $error("downward crossing not wrapped");
  brev_sel_a: assert property ( // RL10
    req_valid && (bitrev_pointer_select == NO_PTR || !bitrev_enable)
    |=> !ea_reversed)
    else $error("reversal active while disabled");
  ofs_nowb_a: assert property ( // RL8
    req_valid && ofs |=> ea_valid && !wb_valid)
    else $error("offset mode wrote pointer back");
  brev_word_a: assert property ( // RL14
    req_valid && brev_on |=> wb_valid && !wb_data[0])
    else $error("bit reversed address odd");
  brev_pri_a: assert property ( // RL15
    req_valid && brev_on |=> ea_reversed && !ea_wrapped)
    else $error("modulo not overridden");
  brev_byte_a: assert property ( // RL13
    req_valid && req_byte |=> !ea_reversed)
    else $error("byte access reversed");
  brev_xrd_a: assert property ( // RL9
    req_valid && req_gen != GEN_XWR |=> !ea_reversed)
    else $error("reversal outside x write");
endmodule : amg_core

// ==== test/amg_core_model.sv ====
// Core-side request issuer for the address generator.
// Assumes the bench hands it one packed request per go pulse.
`timescale 1ns/1ps
module amg_core_model
  import amg_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench request: {gen, reg, ptr, step, mode, byte}
  input  wire logic        go,
  input  wire logic [41:0] cmd,
  // Request towards the generator
  output logic             req_valid,
  output logic      [1:0]  req_gen,
  output logic      [3:0]  req_reg,
  output logic      [15:0] req_ptr,
  output logic      [15:0] req_step,
  output logic      [2:0]  req_mode,
  output logic             req_byte
);
  // Issue on go; between requests the fields flip so stale values never
  // look valid by accident
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_valid <= 1'b0;
      {req_gen, req_reg, req_ptr, req_step, req_mode, req_byte} <= '0;
    end else begin
      req_valid <= go;
      if (go) begin
        {req_gen, req_reg, req_ptr, req_step, req_mode, req_byte} <= cmd;
      end else begin
        {req_gen, req_reg, req_ptr, req_step, req_mode, req_byte} <=
          ~{req_gen, req_reg, req_ptr, req_step, req_mode, req_byte};
      end
    end
  end
endmodule : amg_core_model

// ==== test/modulo_bitrev_address_gen_bench.sv ====
// Self-checking bench for the address generator core.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module modulo_bitrev_address_gen_bench;
  import amg_pkg::*;
  // Bus and request drive
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        go = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, req_gen;
  logic [41:0] cmd = 42'h0;
  // Design answers
  logic        hreadyout, hresp, req_valid, req_byte, ea_valid, wb_valid;
  logic        ea_wrapped, ea_reversed, lr, lb;
  logic [3:0]  req_reg, wb_reg;
  logic [15:0] req_ptr, req_step, ea, wb_data, la;
  logic [2:0]  req_mode;
  // Shadow registers and bookkeeping
  logic [15:0] cfg [0:5];
  logic [31:0] seed = 32'h0000_0035;
  int          err_count = 0, tests_run = 0;

  // Clock of 4 ns
  always #2 hclk = ~hclk;

  amg_core amg_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .req_valid, .req_gen, .req_reg, .req_ptr, .req_step, .req_mode,
    .req_byte, .ea_valid, .ea, .wb_valid, .wb_reg, .wb_data, .ea_wrapped,
    .ea_reversed);

  amg_core_model amg_core_model_inst (.hclk, .hresetn, .go, .cmd,
    .req_valid, .req_gen, .req_reg, .req_ptr, .req_step, .req_mode,
    .req_byte);

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Bit order mirror of a word
  function automatic logic [15:0] rv16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rv16[i] = v[15 - i];
  endfunction : rv16

  // Mirror of a 4-bit index
  function automatic logic [3:0] mir(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction : mir

  // Expected answer for one request under the shadow configuration
  function automatic void expect_of(input logic [41:0] c,
    output logic [15:0] xa, xw, output logic xv, xr, xb);
    logic [1:0]  g;
    logic [3:0]  r;
    logic [15:0] p, s, lo, hi, n;
    logic [2:0]  m;
    logic        b, up, dn, md;
    {g, r, p, s, m, b} = c;
    up = m == M_POSTINC || m == M_PREINC || (m == M_OFFSET && !s[15]);
    dn = m == M_POSTDEC || m == M_PREDEC || (m == M_OFFSET && s[15]);
    n = m == M_IND ? p : ((dn && m != M_OFFSET) ? p - s : p + s);
    xb = g == 2'h1 && !b && (m == M_POSTINC || m == M_PREINC) &&
         cfg[5][15] && cfg[0][11:8] != NO_PTR && r == cfg[0][11:8];
    lo = g == 2'h2 ? cfg[3] : cfg[1];
    hi = g == 2'h2 ? cfg[4] : cfg[2];
    md = m != M_IND && !xb && (g == 2'h2 ?
         cfg[0][14] && cfg[0][7:4] != NO_PTR && r == cfg[0][7:4] :
         cfg[0][15] && cfg[0][3:0] != NO_PTR && r == cfg[0][3:0]);
    xr = md && ((up && n > hi) || (dn && n < lo));
    if (xr) n = up ? n - (hi - lo + 16'h1) : n + (hi - lo + 16'h1);
    if (md && g == 2'h2) n[0] = 1'b0;
    if (xb) n = rv16(rv16(p) + rv16({cfg[5][14:0], 1'b0})) & 16'hFFFE;
    xa = (m == M_POSTINC || m == M_POSTDEC) ? p : n;
    // Y modulo keeps every effective address on a word
    if (g == 2'h2 && cfg[0][14] && cfg[0][7:4] != NO_PTR && r == cfg[0][7:4])
      xa[0] = 1'b0;
    xw = n;
    xv = m inside {[1:4]};
  endfunction : expect_of

  // One comparison
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Single AHB-Lite transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
    if (wr && a < OFS_STAT) cfg[a[4:2]] = d[15:0];
  endtask : bus

  // Register read with expectation
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd_chk

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // One core request; answers are due one cycle after the model issues
  task automatic req(input logic [41:0] c, output logic [15:0] nw);
    logic [15:0] xa;
    logic        xv;
    expect_of(c, xa, nw, xv, lr, lb);
    la = xa;
    @(posedge hclk);
    go  <= 1'b1;
    cmd <= c;
    @(posedge hclk);
    go <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(ea_valid, 1'b1);
    chk(ea, xa);
    chk(wb_valid, xv);
    if (xv || c[3:1] == M_OFFSET) chk(wb_data, nw);
    if (xv) chk(wb_reg, c[39:36]);
    chk(ea_wrapped, lr);
    chk(ea_reversed, lb);
  endtask : req

  // Closing report
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Watchdog against a hung handshake
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] p, lo, w;
    int          len;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, then write and read back with upper half dropped
    rd_chk(OFS_CTRL, {16'h0, RST_CTRL});
    for (int i = 1; i < 8; i++) rd_chk(8'(4 * i), 32'h0);
    wr(OFS_XSTART, 32'hABCD_1000);
    rd_chk(OFS_XSTART, 32'h0000_1000);
    wr(OFS_XEND, 32'h0000_101F);
    wr(OFS_YSTART, 32'h0000_2000);
    wr(OFS_YEND, 32'h0000_2017);
    wr(OFS_STAT, 32'h0000_FFFF);
    wr(8'h20, 32'h0000_FFFF);
    rd_chk(8'h20, 32'h0);
    // Jumps past both bounds of a power-of-two X buffer
    wr(OFS_CTRL, 32'h0000_8FF2);
    req({2'h0, 4'h2, 16'h101C, 16'h0006, M_POSTINC, 1'b0}, w);
    req({2'h1, 4'h2, 16'h1002, 16'h0004, M_PREDEC, 1'b0}, w);
    req({2'h0, 4'h2, 16'h101E, 16'h0004, M_OFFSET, 1'b0}, w);
    // Reversed carry walk over a 16-word buffer aligned to 32 bytes
    wr(OFS_CTRL, 32'h0000_83F3);
    wr(OFS_BREV, 32'h0000_8008);
    p = 16'h1000;
    for (int k = 1; k <= 16; k++) begin
      req({2'h1, 4'h3, p, 16'h0002, M_POSTINC, 1'b0}, p);
      chk(p, {11'h080, mir(4'(k)), 1'b0});
    end
    req({2'h0, 4'h3, 16'h101E, 16'h0004, M_POSTINC, 1'b0}, w);
    req({2'h1, 4'h3, 16'h1000, 16'h0001, M_POSTINC, 1'b1}, w);
    // Random mix of generators, modes and configurations
    for (int i = 0; i < 240; i++) begin
      r = rnd();
      if (i % 24 == 0) begin
        wr(OFS_CTRL, {16'h0, r[31:30], 2'h0,
          r[3] ? 4'hF : {2'h0, r[1:0]}, r[7] ? 4'hF : {2'h0, r[5:4]},
          r[11] ? 4'hF : {2'h0, r[9:8]}});
        wr(OFS_BREV, {16'h0, r[29], 11'h0, r[15:12]});
        r = rnd();
      end
      len = r[17:16] == 2'h2 ? 24 : 32;
      lo  = r[17:16] == 2'h2 ? 16'h2000 : 16'h1000;
      req({r[17:16] == 2'h3 ? 2'h1 : r[17:16], 2'h0, r[19:18],
        lo + 16'(r[31:24] % len),
        r[22:20] == 3'h5 ? 16'(int'(r[15:12] % 17) - 8) : 16'(r[11:8] % 9),
        3'(r[7:0] % 6), r[23]}, w);
    end
    // Status and last address follow the final request
    rd_chk(OFS_STAT, {30'h0, lb, lr});
    rd_chk(OFS_LAST, {16'h0, la});
    give_verdict();
  end
endmodule : modulo_bitrev_address_gen_bench
